// *** verilog/ipc_pkg.sv ***
// Purpose: shared constants and types of the proxy I2C controller
// Assumes: 100 MHz core clock, 40 ns reference tick
// Notes: all register offsets, fields, resets and timing live here
// Behaviour
// - after reset the enable bit (0x05 bit 2) reads 0 and remote accesses never reach the bus.
// - with the enable bit set the block acts as bus controller and replays each remote access.
// - programmed width counts allow standard, fast and fast-plus bus timing.
// - the controller arbitrates with others sharing the bus and a loss never corrupts it.
// - each receive port owns an independent controller instance.
// - contention between the port controllers is settled by normal bus arbitration.
// - timing counts reference periods, or internal oscillator periods of nominal 25 MHz.
// - the SCL high width is 40 ns times the 0x0A count plus four.
// - the SCL low width is 40 ns times the 0x0B count plus four.
// - the local target uses the SCL low count as its SDA setup delay.
// - both counts reset to the value giving at least 5 us at 25 MHz plus 100 ppm.
// - SCL is held low while a forwarded access waits for its remote answer.
package ipc_pkg;
   // -----------------------------------------------------------
   // register map
   // -----------------------------------------------------------
   localparam logic [7:0] REG_GEN_CTL = 8'h05;
   localparam logic [7:0] REG_SCL_HIGH = 8'h0A;
   localparam logic [7:0] REG_SCL_LOW = 8'h0B;
   localparam int CTL_BUSY_LSB = 0;
   localparam int CTL_EN_BIT = 2;
   localparam int CTL_REF_BIT = 3;
   localparam int NUM_PORTS = 2;
   // -----------------------------------------------------------
   // timing
   // -----------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int REF_PERIOD_NS = 40;
   localparam int OSC_FREQ_MHZ = 25;
   localparam int OSC_TOL_PCT = 10;
   localparam int TICK_CYC = (REF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] TICK_LAST = 2'(TICK_CYC - 1);
   localparam int SYNC_EXTRA = 4;
   localparam longint HIGH_MIN_NS = 5000;
   localparam longint REF_PPM = 100;
   localparam longint PPM_BASE = 1000000;
   localparam longint SCL_RST_L = (HIGH_MIN_NS * (PPM_BASE + REF_PPM)
      + longint'(REF_PERIOD_NS) * PPM_BASE - 1)
      / (longint'(REF_PERIOD_NS) * PPM_BASE) - longint'(SYNC_EXTRA);
   localparam logic [7:0] SCL_COUNT_RST = 8'(SCL_RST_L);
   // -----------------------------------------------------------
   // access framing: addr+rw, ack, data, ack
   // -----------------------------------------------------------
   localparam logic [4:0] BIT_ACK1 = 5'h08;
   localparam logic [4:0] BIT_DATA0 = 5'h09;
   localparam logic [4:0] BIT_DATA7 = 5'h10;
   localparam logic [4:0] BIT_LAST = 5'h11;
   localparam logic [7:0] READ_FILL = 8'hFF;
   typedef enum logic [2:0] {
      E_IDLE = 3'b000,
      E_START = 3'b001,
      E_LOW = 3'b011,
      E_RISE = 3'b010,
      E_HIGH = 3'b110,
      E_STOPL = 3'b111,
      E_STOPH = 3'b101,
      E_LOST = 3'b100
   } ipc_eng_state_t;
endpackage

// *** verilog/ipc_bcc_if.sv ***
// Purpose: carrier between a link port endpoint and the core
// Assumes: request fields held stable while a request is open
// Notes: toggles cross domains, data words travel alongside
`timescale 1ns/100ps
interface ipc_bcc_if;
   logic req_tgl;
   logic [6:0] addr;
   logic rw;
   logic [7:0] wdata;
   logic rsp_tgl;
   logic [7:0] rdata;
   logic nack;
   modport link (output req_tgl, addr, rw, wdata, input rsp_tgl, rdata, nack);
   modport core (input req_tgl, addr, rw, wdata, output rsp_tgl, rdata, nack);
endinterface

// *** verilog/ipc_link_port.sv ***
// Purpose: link-clock endpoint of one receive port
// Assumes: core keeps answer words stable after toggling
// Notes: one request outstanding at a time
`timescale 1ns/100ps
module ipc_link_port (
   // link clock and reset
   input wire logic link_clk,
   input wire logic link_rst,
   // request side
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [6:0] req_addr,
   input wire logic req_rw,
   input wire logic [7:0] req_wdata,
   // answer side
   output logic rsp_valid,
   output logic [7:0] rsp_rdata,
   output logic rsp_nack,
   // core carrier
   ipc_bcc_if.link bcc
);
   typedef struct packed {
      logic req_tgl;
      logic [6:0] addr;
      logic rw;
      logic [7:0] wdata;
      logic busy;
      logic [2:0] rs;
      logic seen;
      logic rsp_v;
      logic [7:0] rdata;
      logic nack;
   } ipc_link_st_t;
   ipc_link_st_t q;
   ipc_link_st_t d;
   // -----------------------------------------------------------
   // request capture and answer return
   // -----------------------------------------------------------
   // busy blocks a second request until the answer toggle is back
   always_comb begin
      d = q;
      d.rsp_v = 1'b0;
      d.rs = {q.rs[1:0], bcc.rsp_tgl};
      if (req_valid && !q.busy) begin
         d.addr = req_addr;
         d.rw = req_rw;
         d.wdata = req_wdata;
         d.req_tgl = ~q.req_tgl;
         d.busy = 1'b1;
      end
      if (q.rs[1] == q.rs[2] && q.rs[2] != q.seen) begin
         d.seen = q.rs[2];
         d.busy = 1'b0;
         d.rsp_v = 1'b1;
         d.rdata = bcc.rdata;
         d.nack = bcc.nack;
      end
   end
   // link domain registers
   always_ff @(posedge link_clk) begin
      if (link_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
   // outputs
   assign req_ready = ~q.busy;
   assign rsp_valid = q.rsp_v;
   assign rsp_rdata = q.rdata;
   assign rsp_nack = q.nack;
   assign bcc.req_tgl = q.req_tgl;
   assign bcc.addr = q.addr;
   assign bcc.rw = q.rw;
   assign bcc.wdata = q.wdata;
endmodule

// *** verilog/ipc_top.sv ***
// Purpose: per-port proxy bus controllers replaying remote accesses
// Assumes: open-drain pins resolved outside, pull-ups present
// Notes: one byte read or write per remote request
`timescale 1ns/100ps
module ipc_top (
   // core clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // link clock and reset
   input wire logic link_clk,
   input wire logic link_rst,
   // register port
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // remote requests, link domain
   input wire logic [ipc_pkg::NUM_PORTS-1:0] link_req_valid,
   output logic [ipc_pkg::NUM_PORTS-1:0] link_req_ready,
   input wire logic [ipc_pkg::NUM_PORTS-1:0][6:0] link_req_addr,
   input wire logic [ipc_pkg::NUM_PORTS-1:0] link_req_rw,
   input wire logic [ipc_pkg::NUM_PORTS-1:0][7:0] link_req_wdata,
   output logic [ipc_pkg::NUM_PORTS-1:0] link_rsp_valid,
   output logic [ipc_pkg::NUM_PORTS-1:0][7:0] link_rsp_rdata,
   output logic [ipc_pkg::NUM_PORTS-1:0] link_rsp_nack,
   // local bus pins
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // reference clock detect and local target hooks
   input wire logic ref_clock_present,
   input wire logic target_wait,
   output logic [7:0] target_sda_setup_count
);
   localparam int NP = ipc_pkg::NUM_PORTS;
   typedef struct packed {
      ipc_pkg::ipc_eng_state_t state;
      logic [8:0] cnt;
      logic [1:0] pre;
      logic [4:0] idx;
      logic [17:0] tx;
      logic rw;
      logic [7:0] rdata;
      logic nack;
      logic pend;
      logic [2:0] rs;
      logic seen;
      logic rsp_tgl;
      logic [7:0] rsp_rdata;
      logic rsp_nack;
      logic scl_dr;
      logic sda_dr;
   } ipc_eng_t;
   typedef struct packed {
      logic en;
      logic [7:0] high;
      logic [7:0] low;
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic [2:0] ref_s;
      logic scl_f;
      logic sda_f;
      logic sda_fp;
      logic ref_f;
      logic busy;
      logic [7:0] rdata;
      logic scl_oe;
      logic sda_oe;
      ipc_eng_t [NP-1:0] eng;
   } ipc_top_st_t;
   ipc_top_st_t q;
   ipc_top_st_t d;
   logic [NP-1:0] req_tgl_w;
   logic [NP-1:0][6:0] req_addr_w;
   logic [NP-1:0] req_rw_w;
   logic [NP-1:0][7:0] req_wdata_w;
   // -----------------------------------------------------------
   // link endpoints, one per port
   // -----------------------------------------------------------
   for (genvar p = 0; p < NP; p++) begin : g_port
      ipc_bcc_if bcc ();
      // each port crosses on its own handshake
      ipc_link_port u_link (
         .link_clk(link_clk),
         .link_rst(link_rst),
         .req_valid(link_req_valid[p]),
         .req_ready(link_req_ready[p]),
         .req_addr(link_req_addr[p]),
         .req_rw(link_req_rw[p]),
         .req_wdata(link_req_wdata[p]),
         .rsp_valid(link_rsp_valid[p]),
         .rsp_rdata(link_rsp_rdata[p]),
         .rsp_nack(link_rsp_nack[p]),
         .bcc(bcc.link)
      );
      assign req_tgl_w[p] = bcc.req_tgl;
      assign req_addr_w[p] = bcc.addr;
      assign req_rw_w[p] = bcc.rw;
      assign req_wdata_w[p] = bcc.wdata;
      assign bcc.rsp_tgl = q.eng[p].rsp_tgl;
      assign bcc.rdata = q.eng[p].rsp_rdata;
      assign bcc.nack = q.eng[p].rsp_nack;
   end
   // phase length in ticks, sync periods included
   function automatic logic [8:0] ipc_ticks(input logic [7:0] c);
      ipc_ticks = 9'(c) + 9'(ipc_pkg::SYNC_EXTRA);
   endfunction
   // -----------------------------------------------------------
   // next state
   // -----------------------------------------------------------
   always_comb begin
      ipc_eng_t e;
      logic tick;
      logic done;
      logic cur;
      logic own;
      logic start_c;
      logic stop_c;
      logic any_scl;
      logic any_sda;
      e = '0;
      start_c = 1'b0;
      stop_c = 1'b0;
      tick = 1'b0;
      done = 1'b0;
      cur = 1'b0;
      own = 1'b0;
      any_scl = 1'b0;
      any_sda = 1'b0;
      d = q;
      // three-stage pin filter, a change counts once stages 2 and 3 agree
      d.scl_s = {q.scl_s[1:0], scl_in};
      d.sda_s = {q.sda_s[1:0], sda_in};
      d.ref_s = {q.ref_s[1:0], ref_clock_present};
      if (q.scl_s[1] == q.scl_s[2]) begin
         d.scl_f = q.scl_s[2];
      end
      if (q.sda_s[1] == q.sda_s[2]) begin
         d.sda_f = q.sda_s[2];
      end
      if (q.ref_s[1] == q.ref_s[2]) begin
         d.ref_f = q.ref_s[2];
      end
      d.sda_fp = q.sda_f;
      // bus ownership seen from start and stop conditions
      start_c = q.scl_f && q.sda_fp && !q.sda_f;
      stop_c = q.scl_f && !q.sda_fp && q.sda_f;
      if (start_c) begin
         d.busy = 1'b1;
      end else if (stop_c) begin
         d.busy = 1'b0;
      end
      // register writes
      if (reg_wr_en) begin
         case (reg_addr)
            ipc_pkg::REG_GEN_CTL: d.en = reg_wdata[ipc_pkg::CTL_EN_BIT];
            ipc_pkg::REG_SCL_HIGH: d.high = reg_wdata;
            ipc_pkg::REG_SCL_LOW: d.low = reg_wdata;
            default: d.en = q.en;
         endcase
      end
      // registered read data, unmapped reads return zero
      if (reg_rd_en) begin
         case (reg_addr)
            ipc_pkg::REG_GEN_CTL: begin
               d.rdata = 8'h00;
               d.rdata[ipc_pkg::CTL_EN_BIT] = q.en;
               d.rdata[ipc_pkg::CTL_REF_BIT] = q.ref_f;
               for (int p = 0; p < NP; p++) begin
                  d.rdata[ipc_pkg::CTL_BUSY_LSB + p] = q.eng[p].pend;
               end
            end
            ipc_pkg::REG_SCL_HIGH: d.rdata = q.high;
            ipc_pkg::REG_SCL_LOW: d.rdata = q.low;
            default: d.rdata = 8'h00;
         endcase
      end
      // one independent engine per port; they meet only on the wires
      for (int p = 0; p < NP; p++) begin
         e = q.eng[p];
         e.rs = {q.eng[p].rs[1:0], req_tgl_w[p]};
         // the 40 ns tick stands for a reference or oscillator period
         tick = (q.eng[p].pre == ipc_pkg::TICK_LAST);
         e.pre = tick ? 2'h0 : 2'(q.eng[p].pre + 2'h1);
         if (tick && q.eng[p].cnt != 9'h000) begin
            e.cnt = 9'(q.eng[p].cnt - 9'h001);
         end
         done = (q.eng[p].cnt == 9'h000);
         cur = q.eng[p].tx[5'd17 - q.eng[p].idx];
         own = (q.eng[p].idx < ipc_pkg::BIT_ACK1)
            || (!q.eng[p].rw && q.eng[p].idx >= ipc_pkg::BIT_DATA0
            && q.eng[p].idx <= ipc_pkg::BIT_DATA7);
         // new remote request
         if (q.eng[p].rs[1] == q.eng[p].rs[2] && q.eng[p].rs[2] != q.eng[p].seen) begin
            e.seen = q.eng[p].rs[2];
            e.pend = 1'b1;
            e.rw = req_rw_w[p];
            e.tx = {req_addr_w[p], req_rw_w[p], 1'b1,
               req_rw_w[p] ? ipc_pkg::READ_FILL : req_wdata_w[p], 1'b1};
         end
         case (q.eng[p].state)
            ipc_pkg::E_IDLE: begin
               e.scl_dr = 1'b0;
               e.sda_dr = 1'b0;
               // disabled blocks the start; an idle bus lets all ports race
               if (q.eng[p].pend && q.en && !q.busy) begin
                  e.sda_dr = 1'b1;
                  e.state = ipc_pkg::E_START;
                  e.cnt = ipc_ticks(q.high);
                  e.pre = 2'h0;
                  e.idx = 5'h00;
                  e.nack = 1'b0;
                  e.rdata = 8'h00;
               end
            end
            ipc_pkg::E_START: begin
               if (done) begin
                  e.scl_dr = 1'b1;
                  e.state = ipc_pkg::E_LOW;
                  e.cnt = ipc_ticks(q.low);
                  e.pre = 2'h0;
               end
            end
            ipc_pkg::E_LOW: begin
               // data changes only while SCL is low
               e.sda_dr = ~cur;
               if (done) begin
                  e.scl_dr = 1'b0;
                  e.state = ipc_pkg::E_RISE;
               end
            end
            ipc_pkg::E_RISE: begin
               // a target stretching the clock keeps us here
               if (q.scl_f) begin
                  e.state = ipc_pkg::E_HIGH;
                  e.cnt = ipc_ticks(q.high);
                  e.pre = 2'h0;
               end
            end
            ipc_pkg::E_HIGH: begin
               if (own && cur && !q.sda_f) begin
                  e.scl_dr = 1'b0;
                  e.sda_dr = 1'b0;
                  e.state = ipc_pkg::E_LOST;
               end else if (done) begin
                  if (q.eng[p].idx == ipc_pkg::BIT_ACK1) begin
                     e.nack = q.sda_f;
                  end
                  if (q.eng[p].idx == ipc_pkg::BIT_LAST && !q.eng[p].rw) begin
                     e.nack = q.eng[p].nack | q.sda_f;
                  end
                  if (q.eng[p].rw && q.eng[p].idx >= ipc_pkg::BIT_DATA0
                     && q.eng[p].idx <= ipc_pkg::BIT_DATA7) begin
                     e.rdata = {q.eng[p].rdata[6:0], q.sda_f};
                  end
                  e.scl_dr = 1'b1;
                  e.cnt = ipc_ticks(q.low);
                  e.pre = 2'h0;
                  if (q.eng[p].idx == ipc_pkg::BIT_LAST) begin
                     e.state = ipc_pkg::E_STOPL;
                  end else begin
                     e.idx = 5'(q.eng[p].idx + 5'h01);
                     e.state = ipc_pkg::E_LOW;
                  end
               end
            end
            ipc_pkg::E_STOPL: begin
               e.sda_dr = 1'b1;
               if (done) begin
                  e.scl_dr = 1'b0;
                  e.state = ipc_pkg::E_STOPH;
                  e.cnt = ipc_ticks(q.high);
                  e.pre = 2'h0;
               end
            end
            ipc_pkg::E_STOPH: begin
               // high count restarts until SCL is seen high
               if (!q.scl_f) begin
                  e.cnt = ipc_ticks(q.high);
                  e.pre = 2'h0;
               end else if (done) begin
                  e.sda_dr = 1'b0;
                  e.state = ipc_pkg::E_IDLE;
                  e.pend = 1'b0;
                  e.rsp_tgl = ~q.eng[p].rsp_tgl;
                  e.rsp_rdata = q.eng[p].rdata;
                  e.rsp_nack = q.eng[p].nack;
               end
            end
            ipc_pkg::E_LOST: begin
               // request stays pending; retry once a stop frees the bus
               e.scl_dr = 1'b0;
               e.sda_dr = 1'b0;
               if (!q.busy) begin
                  e.state = ipc_pkg::E_IDLE;
               end
            end
            default: begin
               e.state = ipc_pkg::E_IDLE;
               e.scl_dr = 1'b0;
               e.sda_dr = 1'b0;
            end
         endcase
         d.eng[p] = e;
         any_scl = any_scl | e.scl_dr;
         any_sda = any_sda | e.sda_dr;
      end
      // wired-and of all engines, plus stretch for a waiting target
      d.scl_oe = any_scl | target_wait;
      d.sda_oe = any_sda;
   end
   // -----------------------------------------------------------
   // state register
   // -----------------------------------------------------------
   // SCL and SDA pin filters reset to the idle-high bus level; the reference filter resets low
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         q <= '0;
         q.high <= ipc_pkg::SCL_COUNT_RST;
         q.low <= ipc_pkg::SCL_COUNT_RST;
         q.scl_s <= 3'h7;
         q.sda_s <= 3'h7;
         q.scl_f <= 1'b1;
         q.sda_f <= 1'b1;
         q.sda_fp <= 1'b1;
      end else begin
         q <= d;
      end
   end
   // outputs
   assign reg_rdata = q.rdata;
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe = q.scl_oe;
   assign sda_oe = q.sda_oe;
   assign target_sda_setup_count = q.low;
   // -----------------------------------------------------------
   // checks
   // -----------------------------------------------------------
   AST_EN_RESET: assert property (@(posedge clock) sys_rst |=> !q.en)
      else $error("enable not cleared by reset");
   AST_CNT_RESET: assert property (@(posedge clock)
      sys_rst |=> (q.high == 8'h7A && q.low == 8'h7A))
      else $error("width counts reset wrong");
   AST_STRETCH: assert property (@(posedge clock) disable iff (sys_rst)
      target_wait |=> scl_oe)
      else $error("scl not held during target wait");
   AST_SETUP: assert property (@(posedge clock) disable iff (sys_rst)
      (reg_wr_en && reg_addr == ipc_pkg::REG_SCL_LOW)
      |=> (target_sda_setup_count == $past(reg_wdata)))
      else $error("setup count differs from low count");
   for (genvar p = 0; p < NP; p++) begin : g_chk
      logic [11:0] pc;
      // cycles spent in the current engine state
      always_ff @(posedge clock) begin
         if (sys_rst) begin
            pc <= 12'h000;
         end else begin
            pc <= (d.eng[p].state != q.eng[p].state) ? 12'h000 : 12'(pc + 12'h001);
         end
      end
      AST_NO_START_OFF: assert property (@(posedge clock) disable iff (sys_rst)
         (q.eng[p].state == ipc_pkg::E_IDLE && !q.en) |=> q.eng[p].state == ipc_pkg::E_IDLE)
         else $error("engine started while disabled");
      AST_LOW_WIDTH: assert property (@(posedge clock) disable iff (sys_rst)
         (q.eng[p].state == ipc_pkg::E_LOW && d.eng[p].state == ipc_pkg::E_RISE)
         |-> (int'(pc) == (int'(q.low) + 4) * 4))
         else $error("scl low width wrong");
      AST_HIGH_WIDTH: assert property (@(posedge clock) disable iff (sys_rst)
         (q.eng[p].state == ipc_pkg::E_HIGH && d.eng[p].state == ipc_pkg::E_LOW)
         |-> (int'(pc) == (int'(q.high) + 4) * 4))
         else $error("scl high width wrong");
      AST_WAIT_HIGH: assert property (@(posedge clock) disable iff (sys_rst)
         (q.eng[p].state == ipc_pkg::E_RISE && !q.scl_f) |=> q.eng[p].state == ipc_pkg::E_RISE)
         else $error("high phase began with scl low");
      AST_LOST_FREE: assert property (@(posedge clock) disable iff (sys_rst)
         q.eng[p].state == ipc_pkg::E_LOST |-> !q.eng[p].scl_dr && !q.eng[p].sda_dr)
         else $error("lines driven after loss");
      AST_LOST_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
         (q.eng[p].state == ipc_pkg::E_LOST && q.busy) |=> q.eng[p].state == ipc_pkg::E_LOST)
         else $error("retry before bus idle");
      AST_ARB_LOSS: assert property (@(posedge clock) disable iff (sys_rst)
         (q.eng[p].state == ipc_pkg::E_HIGH && !q.eng[p].sda_dr
         && q.eng[p].idx < 5'h08 && !q.sda_f) |=> q.eng[p].state == ipc_pkg::E_LOST)
         else $error("arbitration loss missed");
   end
endmodule

// *** testbench/ipc_bus_target.sv ***
// Purpose: bus target model facing the proxy controller
// Assumes: bench resolves lines with pull-ups
// Notes: acks address 2A, reads give C5
`timescale 1ns/100ps
module ipc_bus_target (
   // resolved lines, stretch request
   input wire logic scl,
   input wire logic sda,
   input wire logic slow,
   // pulls and received byte
   output logic scl_oe = 1'b0,
   output logic sda_oe = 1'b0,
   output logic [7:0] got = 8'h00
);
   localparam logic [7:0] RD = 8'hC5;
   logic [4:0] n = 5'h00;
   logic [7:0] sh = 8'h00;
   logic hit = 1'b0, rw = 1'b0;
   // start is data falling while clock high
   always @(negedge sda) if (scl) n = 5'h00;
   always @(posedge scl) {sh, n} = {sh[6:0], sda, n + 5'h01};
   // data moves only after the clock fell, never while high
   always @(negedge scl) begin
      if (n == 5'h08) {hit, rw} = {sh[7:1] == 7'h2A, sh[0]};
      if (n == 5'h11 && !rw) got = sh;
      sda_oe = hit && (n == 5'h08 || (n == 5'h11 && !rw)
         || (rw && n > 5'h08 && n < 5'h11 && !RD[5'h10 - n]));
   end
   // slow mode holds the clock past the low phase
   always @(negedge scl) if (slow) begin
      scl_oe = 1'b1;
      #1000 scl_oe = 1'b0;
   end
endmodule

// *** testbench/tb_top.sv ***
// Purpose: self-checking bench of the proxy controller
// Assumes: at most one remote access in flight per port
// Notes: short width counts keep the run brief
`timescale 1ns/100ps
module tb_top;
   logic clock = 0, sys_rst = 1, link_clk = 0, link_rst = 1, slow = 0, target_wait = 0;
   logic reg_wr_en = 0, reg_rd_en = 0, ref_clock_present = 0;
   logic scl_out, scl_oe, sda_out, sda_oe, t_scl, t_sda;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, target_sda_setup_count, got, d;
   logic [1:0] link_req_valid = 2'h0, link_req_rw = 2'h0, link_req_ready;
   logic [1:0] link_rsp_valid, link_rsp_nack;
   logic [1:0][6:0] link_req_addr = '0;
   logic [1:0][7:0] link_req_wdata = '0, link_rsp_rdata;
   logic [9:0] e, exp_q[$];
   int fail_count = 0, n_compared = 0, cyc = 0, run = 0, max_run = 0, seed = 32'h1BCB;
   // released lines float high
   wire scl_in = ~(scl_oe | t_scl), sda_in = ~(sda_oe | t_sda);
   always #5 clock = ~clock;
   always #6 link_clk = ~link_clk;
   ipc_top ipc_top_i (.clock, .sys_rst, .link_clk, .link_rst, .reg_wr_en, .reg_rd_en,
      .reg_addr, .reg_wdata, .reg_rdata, .link_req_valid, .link_req_ready, .link_req_addr,
      .link_req_rw, .link_req_wdata, .link_rsp_valid, .link_rsp_rdata, .link_rsp_nack, .scl_in,
      .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe, .ref_clock_present, .target_wait,
      .target_sda_setup_count);
   ipc_bus_target ipc_bus_target_i (.scl(scl_in), .sda(sda_in), .slow, .scl_oe(t_scl),
      .sda_oe(t_sda), .got);
   // every comparison lands here
   task automatic chk(input logic [8:0] s, input logic [8:0] x);
      n_compared++;
      if (s !== x) begin
         fail_count++;
         $display("[ERR] %0t saw %h want %h", $time, s, x);
      end
   endtask
   task automatic tally_and_finish();
      if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // register cycle; read data checked once settled
   task automatic rg(input logic w, input logic [7:0] a, input logic [7:0] v);
      @(negedge clock);
      {reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = {w, !w, a, v};
      @(negedge clock);
      {reg_wr_en, reg_rd_en} = 2'h0;
      @(negedge clock);
      if (!w) chk({1'b0, reg_rdata}, {1'b0, v});
   endtask
   // remote access, held until taken, then await answer
   task automatic req(input int p, input logic [6:0] a, input logic rw, input logic [7:0] v,
         input logic [9:0] x);
      exp_q.push_back(x);
      @(negedge link_clk);
      {link_req_valid[p], link_req_addr[p], link_req_rw[p], link_req_wdata[p]} = {1'b1, a, rw, v};
      do @(posedge link_clk); while (link_req_ready[p] !== 1'b1);
      @(negedge link_clk);
      link_req_valid[p] = 1'b0;
      do @(posedge link_clk); while (link_rsp_valid[p] !== 1'b1);
   endtask
   // answers matched to oldest note; bit 9 says data matters
   always @(posedge link_clk)
      for (int p = 0; p < 2; p++)
         if (link_rsp_valid[p] === 1'b1) begin
            e = exp_q.pop_front();
            chk({link_rsp_nack[p], e[9] ? link_rsp_rdata[p] : e[7:0]}, e[8:0]);
         end
   // longest clock pull seen, and hang guard
   always @(posedge clock) begin
      cyc++;
      run = scl_oe === 1'b1 ? run + 1 : 0;
      max_run = run > max_run ? run : max_run;
      if (cyc == 50000) chk(9'h000, 9'h1FF);
      if (cyc == 50000) tally_and_finish();
   end
   // main sequence
   initial begin
      repeat (6) @(negedge clock);
      sys_rst = 0;
      link_rst = 0;
      rg(0, 8'h05, 8'h00);
      rg(0, 8'h0A, 8'h7A);
      rg(0, 8'h3C, 8'h00);
      rg(1, 8'h0A, 8'h01);
      rg(1, 8'h0B, 8'h02);
      chk({1'b0, target_sda_setup_count}, 9'h002);
      d = 8'($random(seed));
      fork
         req(0, 7'h2A, 1'b0, d, 10'h000);
      join_none
      repeat (400) @(negedge clock);
      chk({8'h00, max_run == 0}, 9'h001);
      rg(0, 8'h05, 8'h01);
      rg(1, 8'h05, 8'h04);
      wait fork;
      chk({1'b0, got}, {1'b0, d});
      req(1, 7'h2A, 1'b1, 8'h00, 10'h2C5);
      req(1, 7'h15, 1'b0, 8'h5A, 10'h100);
      // both ports race; port 0 loses on the address lsb and retries after the stop
      fork
         req(1, 7'h2A, 1'b0, 8'hF0, 10'h000);
         begin
            #1 req(0, 7'h2B, 1'b0, 8'h0F, 10'h100);
         end
      join
      chk({1'b0, got}, 9'h00F);
      chk({1'b0, 8'(max_run)}, 9'h019);
      slow = 1;
      rg(1, 8'h0A, 8'h06);
      rg(1, 8'h0B, 8'h0C);
      max_run = 0;
      req(0, 7'h2A, 1'b1, 8'h00, 10'h2C5);
      chk({1'b0, 8'(max_run)}, 9'h041);
      @(negedge clock);
      {ref_clock_present, target_wait} = 2'h3;
      repeat (4) @(negedge clock);
      chk({8'h00, scl_oe}, 9'h001);
      chk({7'h00, scl_out, sda_out}, 9'h000);
      rg(0, 8'h05, 8'h0C);
      tally_and_finish();
   end
endmodule
